// ==== temp_monitor_pkg.sv ====
// package of constants and types for the temperature monitor status and mask registers
// Contract
// - mask bit 3 blocks channel 4 overtemp output
// - mask bit 0 blocks channel 1 overtemp output
// - alert bit 6 set: local above limit
// - alert bit n-1 set: remote n above limit
// - overtemp bit 0 set: channel 1 above limit
// - overtemp bit 3 set: channel 4 above limit
// - fault bit n set: diode open or shorted
// - fault bits 5,6 read 0 then 1
// - mask and status registers reset to zero
// - alert status read clears, sets next conversion
// - alert output follows flags, cleared by read/response
// - overtemp read clears flags, not the output
// - overtemp condition ends below limit minus 4C
package temp_monitor_pkg;
	// ****************************************************************
	// register addresses
	// ****************************************************************
	localparam logic [7:0] ADDR_MASK_CFG = 8'h43;
	localparam logic [7:0] ADDR_ALERT_ST = 8'h44;
	localparam logic [7:0] ADDR_OVT_ST = 8'h45;
	localparam logic [7:0] ADDR_FAULT_ST = 8'h46;
	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int CH1_MASK_BIT = 0;
	localparam int CH4_MASK_BIT = 3;
	localparam int LOCAL_ALERT_BIT = 6;
	localparam int CH1_OVT_BIT = 0;
	localparam int CH4_OVT_BIT = 3;
	localparam logic [7:0] MASK_WRITABLE = 8'h09;
	localparam logic [7:0] FAULT_FILLER = 8'h60;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] HYST_DEG_C = 8'h04;
	localparam int NUM_REMOTE = 4;
	// one finished conversion result for one channel (0 local, 1..4 remote)
	typedef struct packed {
		logic valid;
		logic [2:0] chan;
		logic [7:0] temp;
		logic [7:0] alert_limit;
		logic [7:0] ovt_limit;
		logic diode_fault;
	} conv_result_t;
	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

// ==== temp_monitor_status_mask_regs.sv ====
// status and overtemperature mask register group
`timescale 1ns/1ps
module temp_monitor_status_mask_regs import temp_monitor_pkg::*; (
	// clock, reset, enable
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// conversion engine result
	input wire conv_result_t i_conv,
	// register access from bus interface
	input wire reg_req_t i_req,
	input wire logic i_alert_response,
	output logic [7:0] o_rdata,
	// outputs
	output logic o_alert,
	output logic o_overtemp_shutdown_line
);
	logic [7:0] overtemp_mask_config;
	logic [7:0] alert_status;
	logic [7:0] overtemp_status;
	logic [7:0] diode_fault_status;
	logic por_done;
	logic alert_line;
	logic [NUM_REMOTE:1] ovt_cond;
	logic [8:0] lim_minus_hyst;
	logic conv_above_alert;
	logic conv_above_ovt;
	logic rd_alert;
	logic rd_ovt;

	// ****************************************************************
	// comparisons on a finished conversion
	// ****************************************************************
	assign conv_above_alert = i_conv.valid && (i_conv.temp > i_conv.alert_limit);
	assign conv_above_ovt = i_conv.valid && (i_conv.temp > i_conv.ovt_limit);
	assign lim_minus_hyst = {1'b0, i_conv.ovt_limit} - {1'b0, HYST_DEG_C};
	assign rd_alert = i_req.rd && (i_req.addr == ADDR_ALERT_ST);
	assign rd_ovt = i_req.rd && (i_req.addr == ADDR_OVT_ST);

	// mask register, only two bits exist
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			overtemp_mask_config <= REG_RESET;
		end else if (i_clk_en && i_req.wr && i_req.addr == ADDR_MASK_CFG) begin
			overtemp_mask_config <= i_req.wdata & MASK_WRITABLE;
		end
	end

	// alert flags: new set beats the read clear so no event is lost
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			alert_status <= REG_RESET;
		end else if (i_clk_en) begin
			for (int b = 0; b < 8; b++) begin
				if (conv_above_alert && i_conv.chan == 3'd0 && b == LOCAL_ALERT_BIT) begin
					alert_status[b] <= 1'b1;
				end else if (conv_above_alert && i_conv.chan != 3'd0 &&
					i_conv.chan <= 3'(NUM_REMOTE) && b == int'(i_conv.chan) - 1) begin
					alert_status[b] <= 1'b1;
				end else if (rd_alert) begin
					alert_status[b] <= 1'b0;
				end
			end
		end
	end

	// alert line: raised with a new flag, dropped by read or alert response
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			alert_line <= 1'b0;
		end else if (i_clk_en) begin
			if (conv_above_alert) begin
				alert_line <= 1'b1;
			end else if (rd_alert || i_alert_response) begin
				alert_line <= 1'b0;
			end
		end
	end
	assign o_alert = alert_line;

	// overtemp condition with hysteresis, per remote channel
	genvar g;
	generate
		for (g = 1; g <= NUM_REMOTE; g++) begin : g_ovt
			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_n) begin
					ovt_cond[g] <= 1'b0;
				end else if (i_clk_en && i_conv.valid && i_conv.chan == 3'(g)) begin
					if (conv_above_ovt) begin
						ovt_cond[g] <= 1'b1;
					end else if (lim_minus_hyst[8] ||
						{1'b0, i_conv.temp} < lim_minus_hyst) begin
						ovt_cond[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// overtemp flags: only channels 1 and 4 have them, read clears
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			overtemp_status <= REG_RESET;
		end else if (i_clk_en) begin
			if (conv_above_ovt && i_conv.chan == 3'd1) begin
				overtemp_status[CH1_OVT_BIT] <= 1'b1;
			end else if (rd_ovt) begin
				overtemp_status[CH1_OVT_BIT] <= 1'b0;
			end
			if (conv_above_ovt && i_conv.chan == 3'd4) begin
				overtemp_status[CH4_OVT_BIT] <= 1'b1;
			end else if (rd_ovt) begin
				overtemp_status[CH4_OVT_BIT] <= 1'b0;
			end
		end
	end

	// shutdown line follows the hysteresis condition, not the flags,
	// so a status read cannot release it
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_overtemp_shutdown_line <= 1'b0;
		end else if (i_clk_en) begin
			o_overtemp_shutdown_line <=
				(ovt_cond[1] && !overtemp_mask_config[CH1_MASK_BIT]) ||
				(ovt_cond[4] && !overtemp_mask_config[CH4_MASK_BIT]);
		end
	end

	// diode fault bits follow the latest conversion of each remote channel
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			diode_fault_status <= REG_RESET;
			por_done <= 1'b0;
		end else if (i_clk_en) begin
			por_done <= 1'b1;
			if (i_conv.valid && i_conv.chan != 3'd0 && i_conv.chan <= 3'(NUM_REMOTE)) begin
				diode_fault_status[i_conv.chan] <= i_conv.diode_fault;
			end
		end
	end

	// read data register
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_rdata <= REG_RESET;
		end else if (i_clk_en && i_req.rd) begin
			unique case (i_req.addr)
				ADDR_MASK_CFG: o_rdata <= overtemp_mask_config;
				ADDR_ALERT_ST: o_rdata <= alert_status;
				ADDR_OVT_ST: o_rdata <= overtemp_status;
				ADDR_FAULT_ST: o_rdata <= (diode_fault_status & 8'h1E) |
					(por_done ? FAULT_FILLER : REG_RESET);
				default: o_rdata <= REG_RESET;
			endcase
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence ch4_hot_s;
		i_clk_en && i_conv.valid && i_conv.chan == 3'd4 && conv_above_ovt;
	endsequence
	ch4_mask_block_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && overtemp_mask_config == 8'h08 && !ovt_cond[1] |=>
		!o_overtemp_shutdown_line)
		else $error("shutdown asserted for masked channel 4");
	ch1_mask_block_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && overtemp_mask_config == 8'h01 && !ovt_cond[4] |=>
		!o_overtemp_shutdown_line)
		else $error("shutdown asserted for masked channel 1");
	local_alert_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && conv_above_alert && i_conv.chan == 3'd0 |=> alert_status[6] && o_alert)
		else $error("local alert flag not set");
	ch4_ovt_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		ch4_hot_s |=> overtemp_status[3] && ovt_cond[4])
		else $error("channel 4 overtemp flag not set");
	ovt_read_keep_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && rd_ovt && !i_conv.valid |=> overtemp_status == 8'h00 &&
		$stable(ovt_cond))
		else $error("overtemp read misbehaved");
	alert_read_clr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && rd_alert && !i_conv.valid |=> alert_status == 8'h00 && !o_alert)
		else $error("alert read did not clear");
	mask_reserved_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(overtemp_mask_config & 8'hF6) == 8'h00)
		else $error("reserved mask bit set");
	filler_bits_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && i_req.rd && i_req.addr == ADDR_FAULT_ST && por_done |=> o_rdata[6:5] == 2'b11)
		else $error("fault filler bits not one");
	sequence ch1_hot_s;
		i_clk_en && i_conv.valid && i_conv.chan == 3'd1 && conv_above_ovt;
	endsequence
	sequence remote_done_s;
		i_clk_en && i_conv.valid && i_conv.chan != 3'd0 && i_conv.chan <= 3'(NUM_REMOTE);
	endsequence
	ch1_ovt_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		ch1_hot_s |=> overtemp_status[0] && ovt_cond[1])
		else $error("channel 1 overtemp flag not set");
	remote_alert_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		remote_done_s ##0 conv_above_alert |=>
		alert_status[$past(i_conv.chan) - 3'd1] && o_alert)
		else $error("remote alert flag not set");
	diode_fault_track_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		remote_done_s |=>
		diode_fault_status[$past(i_conv.chan)] == $past(i_conv.diode_fault))
		else $error("diode fault bit does not follow conversion");
	hyst_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		remote_done_s ##0 (ovt_cond[i_conv.chan] && i_conv.ovt_limit >= HYST_DEG_C &&
		{1'b0, i_conv.temp} + {1'b0, HYST_DEG_C} >= {1'b0, i_conv.ovt_limit}) |=>
		ovt_cond[$past(i_conv.chan)])
		else $error("overtemp condition dropped inside hysteresis");
	hyst_release_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		remote_done_s ##0 (i_conv.ovt_limit >= HYST_DEG_C &&
		{1'b0, i_conv.temp} + {1'b0, HYST_DEG_C} < {1'b0, i_conv.ovt_limit}) |=>
		!ovt_cond[$past(i_conv.chan)])
		else $error("overtemp condition held below hysteresis");
	ovt_read_line_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && rd_ovt && ovt_cond[1] && !overtemp_mask_config[CH1_MASK_BIT] |=>
		o_overtemp_shutdown_line)
		else $error("overtemp read released the shutdown line");
	alert_resp_clr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && i_alert_response && !i_conv.valid |=> !o_alert)
		else $error("alert response did not clear alert");
	fault_por_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_clk_en && i_req.rd && i_req.addr == ADDR_FAULT_ST && !por_done |=>
		o_rdata == 8'h00)
		else $error("fault filler bits not zero after reset");
	regs_reset_zero_a: assert property (@(posedge i_clk_sys)
		!i_rst_n |=> overtemp_mask_config == 8'h00 && alert_status == 8'h00 &&
		overtemp_status == 8'h00 && diode_fault_status == 8'h00 && !o_alert &&
		!o_overtemp_shutdown_line)
		else $error("register not zero after reset");
	status_reserved_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(alert_status & 8'hB0) == 8'h00 && (overtemp_status & 8'hF6) == 8'h00)
		else $error("reserved status bit set");
	en_freeze_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!i_clk_en |=> $stable(alert_status) && $stable(overtemp_status) &&
		$stable(o_rdata) && $stable(o_alert) && $stable(ovt_cond))
		else $error("state moved while enable low");
endmodule

// ==== conv_engine_model.sv ====
// conversion engine model feeding finished channel results
`timescale 1ns/1ps
module conv_engine_model import temp_monitor_pkg::*; (
	// clock and result
	input wire logic i_clk_sys,
	output conv_result_t o_conv
);
	initial o_conv = '0;
	// one valid pulse per result, launched on the falling edge
	task automatic send(input logic [2:0] ch, input logic [7:0] t, input logic [7:0] lim,
		input logic flt);
		@(negedge i_clk_sys);
		o_conv = {1'b1, ch, t, lim, lim, flt};
		@(negedge i_clk_sys);
		// stale fields are inverted so nothing can lean on a held value
		o_conv = {1'b0, ~o_conv[27:0]};
		@(negedge i_clk_sys);
	endtask
endmodule

// ==== tb_temp_monitor_status_mask_regs.sv ====
// self-checking testbench for the status and mask register group
`timescale 1ns/1ps
module tb_temp_monitor_status_mask_regs import temp_monitor_pkg::*; ;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_alert_response = 1'b0;
	logic i_clk_en = 1'b1;
	reg_req_t i_req = '0;
	conv_result_t i_conv;
	logic [7:0] o_rdata;
	logic o_alert;
	logic o_shut;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	always #20 i_clk_sys = ~i_clk_sys;
	temp_monitor_status_mask_regs temp_monitor_status_mask_regs_inst (
		.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_conv(i_conv),
		.i_req(i_req), .i_alert_response(i_alert_response), .o_rdata(o_rdata),
		.o_alert(o_alert), .o_overtemp_shutdown_line(o_shut));
	conv_engine_model conv_engine_model_inst (.i_clk_sys(i_clk_sys), .o_conv(i_conv));
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one-cycle request on the falling edge; address and data scrambled once released
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
		@(negedge i_clk_sys);
		i_req = {wr, ~wr, addr, wd};
		@(negedge i_clk_sys);
		i_req = {2'b00, ~addr, ~wd};
	endtask
	// read data is registered, so it is settled by the falling edge after the take
	task automatic read_chk(input logic [7:0] addr, input logic [7:0] exp);
		access(1'b0, addr, 8'h00);
		check(o_rdata, exp);
	endtask
	// hang guard, well above the roughly 115 cycles the sequence needs
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			give_verdict();
		end
	end
	// main sequence
	initial begin
		repeat (8) @(negedge i_clk_sys);
		i_rst_n = 1'b1;
		check({6'h0, o_alert, o_shut}, 8'h00);
		read_chk(ADDR_MASK_CFG, REG_RESET);
		read_chk(ADDR_ALERT_ST, REG_RESET);
		read_chk(ADDR_OVT_ST, REG_RESET);
		read_chk(ADDR_FAULT_ST, FAULT_FILLER);
		access(1'b1, ADDR_MASK_CFG, 8'hff);
		access(1'b1, ADDR_ALERT_ST, 8'hff);
		read_chk(ADDR_MASK_CFG, 8'h09);
		read_chk(ADDR_ALERT_ST, 8'h00);
		// every channel one degree over both limits, channels 1 and 4 masked
		for (int ch = 0; ch <= NUM_REMOTE; ch++) begin
			conv_engine_model_inst.send(3'(ch), 8'h50, 8'h4f, 1'b0);
		end
		check({6'h0, o_alert, o_shut}, 8'h02);
		read_chk(ADDR_ALERT_ST, 8'h4f);
		check({6'h0, o_alert, o_shut}, 8'h00);
		read_chk(ADDR_ALERT_ST, 8'h00);
		read_chk(ADDR_OVT_ST, 8'h09);
		read_chk(ADDR_OVT_ST, 8'h00);
		// channel 4 masked, channel 1 hot raises the line; alert response and overtemp read keep it up
		access(1'b1, ADDR_MASK_CFG, 8'h08);
		conv_engine_model_inst.send(3'd1, 8'h50, 8'h4f, 1'b0);
		check({6'h0, o_alert, o_shut}, 8'h03);
		@(negedge i_clk_sys);
		i_alert_response = 1'b1;
		@(negedge i_clk_sys);
		i_alert_response = 1'b0;
		check({6'h0, o_alert, o_shut}, 8'h01);
		read_chk(ADDR_OVT_ST, 8'h01);
		check({7'h0, o_shut}, 8'h01);
		// hysteresis: limit minus 3 and minus 4 hold, minus 5 releases
		conv_engine_model_inst.send(3'd1, 8'h4c, 8'h4f, 1'b0);
		conv_engine_model_inst.send(3'd1, 8'h4b, 8'h4f, 1'b0);
		check({7'h0, o_shut}, 8'h01);
		conv_engine_model_inst.send(3'd1, 8'h4a, 8'h4f, 1'b0);
		check({7'h0, o_shut}, 8'h00);
		read_chk(ADDR_ALERT_ST, 8'h01);
		// equal to the limit is not over it; diode fault follows each conversion
		conv_engine_model_inst.send(3'd2, 8'h4f, 8'h4f, 1'b1);
		read_chk(ADDR_ALERT_ST, 8'h00);
		read_chk(ADDR_FAULT_ST, 8'h64);
		conv_engine_model_inst.send(3'd2, 8'h10, 8'h4f, 1'b0);
		read_chk(ADDR_FAULT_ST, 8'h60);
		// unmasking channel 4 puts its held condition on the line
		access(1'b1, ADDR_MASK_CFG, 8'h00);
		@(negedge i_clk_sys);
		check({7'h0, o_shut}, 8'h01);
		conv_engine_model_inst.send(3'd4, 8'h10, 8'h4f, 1'b0);
		check({7'h0, o_shut}, 8'h00);
		// channel 1 masked and hot: flag set, line stays low
		access(1'b1, ADDR_MASK_CFG, 8'h01);
		conv_engine_model_inst.send(3'd1, 8'h50, 8'h4f, 1'b0);
		check({7'h0, o_shut}, 8'h00);
		read_chk(ADDR_OVT_ST, 8'h01);
		// a conversion while the enable is low is never seen
		i_clk_en = 1'b0;
		conv_engine_model_inst.send(3'd3, 8'h50, 8'h4f, 1'b1);
		check({6'h0, o_alert, o_shut}, 8'h02);
		i_clk_en = 1'b1;
		read_chk(ADDR_FAULT_ST, 8'h60);
		read_chk(ADDR_ALERT_ST, 8'h01);
		// second reset in mid-run with flags, mask and line all set
		conv_engine_model_inst.send(3'd4, 8'h50, 8'h4f, 1'b1);
		check({6'h0, o_alert, o_shut}, 8'h03);
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_clk_sys);
		i_rst_n = 1'b1;
		i_req = {1'b0, 1'b1, ADDR_FAULT_ST, 8'h00};
		@(negedge i_clk_sys);
		i_req = '0;
		check(o_rdata, REG_RESET);
		check({6'h0, o_alert, o_shut}, 8'h00);
		read_chk(ADDR_MASK_CFG, REG_RESET);
		read_chk(ADDR_ALERT_ST, REG_RESET);
		read_chk(ADDR_OVT_ST, REG_RESET);
		read_chk(ADDR_FAULT_ST, FAULT_FILLER);
		give_verdict();
	end
endmodule
